// ==== verilog/xdmd_regs.svh ====
// constants for the external-data map decoder
`ifndef XDMD_REGS_SVH
`define XDMD_REGS_SVH

// ****************************************************************
// special function register addresses
// ****************************************************************
`define XDMD_SFR_SYSCTL 8'hb1
`define XDMD_SFR_PAGE 8'h91
`define XDMD_SFR_P2 8'ha0

// ****************************************************************
// system control fields and reset values
// ****************************************************************
`define XDMD_SC_DIS_BIT 0
`define XDMD_SC_VIS_BIT 1
`define XDMD_SC_GEN_LO 4
`define XDMD_SC_GEN_HI 5
`define XDMD_SC_DIS_RST 1'b1
`define XDMD_SC_VIS_RST 1'b0
`define XDMD_SC_GEN_RST 2'b10
`define XDMD_PAGE_RST 8'h00
`define XDMD_P2_RST 8'hff

// ****************************************************************
// internal windows in the external data space
// ****************************************************************
`define XDMD_LCD_LO 16'hf3dc
`define XDMD_LCD_HI 16'hf3ef
`define XDMD_RTC_LO 16'hf3f0
`define XDMD_RTC_HI 16'hf3ff
`define XDMD_GAP_LO 16'hf400
`define XDMD_GAP_HI 16'hfeff
`define XDMD_ON_CHIP_XDATA_RAM_LO 16'hff00
`define XDMD_GAP_DATA 8'h00

`endif

// ==== verilog/xdmd_pkg.sv ====
// types shared by the external-data map decoder
package xdmd_pkg;

    typedef enum logic [2:0] {
        XDMD_TGT_EXT,
        XDMD_TGT_LCD,
        XDMD_TGT_RTC,
        XDMD_TGT_GAP,
        XDMD_TGT_ON_CHIP_XDATA_RAM
    } xdmd_target_t;

    typedef enum logic [1:0] {
        XDMD_ST_IDLE,
        XDMD_ST_CYC1,
        XDMD_ST_CYC2
    } xdmd_state_t;

    typedef struct packed {
        logic wr;
        logic ptr16;
        logic [15:0] pointer;
        logic [7:0] index;
        logic [7:0] wdata;
    } xdmd_move_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } xdmd_sfr_t;

endpackage

// ==== verilog/xdmd_on_chip_xdata_ram.sv ====
// on-chip external-data ram, no reset on its contents
module xdmd_on_chip_xdata_ram
    import xdmd_pkg::*;
#(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic clk_sys_i, // system clock
    input wire logic we_i, // write strobe
    input wire logic [AW-1:0] addr_i, // word address
    input wire logic [DW-1:0] wdata_i, // write data
    output logic [DW-1:0] rdata_o // read data, combinational
);

    // contents survive reset and are unknown at power-up
    logic [DW-1:0] mem_r [2**AW];

    always_ff @(posedge clk_sys_i) begin
        if (we_i) begin
            mem_r[addr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem_r[addr_i];

endmodule

// ==== verilog/xdmd_decoder.sv ====
// external-data move decoder: internal windows versus external bus
`include "xdmd_regs.svh"

module xdmd_decoder
    import xdmd_pkg::*;
#(
    parameter int MC_CLKS = 6 // clocks per machine cycle
) (
    input wire logic clk_sys_i, // system clock
    input wire logic srst_i, // synchronous reset, active high
    input wire logic mv_req_i, // move request pulse
    input wire xdmd_move_t mv_i, // move descriptor
    output logic mv_busy_o, // move in progress
    output logic mv_done_o, // move finished pulse
    output logic [7:0] mv_rdata_o, // read result
    input wire xdmd_sfr_t sfr_i, // special register access
    output logic [7:0] sfr_rdata_o, // special register read data
    output logic [7:0] p2_latch_o, // port 2 latch
    output logic [15:0] ext_addr_o, // address on ports 0 and 2
    output logic ext_hi_bus_o, // port 2 carries address
    output logic ext_lo_bus_o, // port 0 carries address/data
    output logic [7:0] ext_data_o, // port 0 write data
    output logic ext_data_oe_o, // port 0 data drive enable
    input wire logic [7:0] ext_data_i, // port 0 pin level
    output logic ext_rd_n_o, // read strobe, active low
    output logic ext_wr_n_o, // write strobe, active low
    output logic lcd_sel_o, // lcd register access pulse
    output logic rtc_sel_o, // rtc register access pulse
    output logic per_wr_o, // peripheral write flag
    output logic [7:0] per_addr_o, // peripheral register offset
    output logic [7:0] per_wdata_o, // peripheral write data
    input wire logic [7:0] lcd_rdata_i, // lcd read data
    input wire logic [7:0] rtc_rdata_i // rtc read data
);

    localparam int CW = $clog2(MC_CLKS + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(MC_CLKS - 1);

    // ****************************************************************
    // pin input synchroniser
    // ****************************************************************
    logic [7:0] pin_meta_r;
    logic [7:0] pin_sync_r;

    always_ff @(posedge clk_sys_i) begin
        pin_meta_r <= ext_data_i;
        pin_sync_r <= pin_meta_r;
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    logic dis_r;
    logic dis_nxt;
    logic vis_r;
    logic vis_nxt;
    logic [1:0] gen_r;
    logic [1:0] gen_nxt;
    logic [7:0] page_r;
    logic [7:0] page_nxt;
    logic [7:0] p2_r;
    logic [7:0] p2_nxt;
    logic [7:0] sfr_rd_r;
    logic [7:0] sfr_rd_nxt;

    always_comb begin
        dis_nxt = dis_r;
        vis_nxt = vis_r;
        gen_nxt = gen_r;
        page_nxt = page_r;
        p2_nxt = p2_r;
        sfr_rd_nxt = sfr_rd_r;
        if (sfr_i.wr) begin
            if (sfr_i.addr == `XDMD_SFR_SYSCTL) begin
                // one-way latch: software can only clear it
                dis_nxt = dis_r & sfr_i.wdata[`XDMD_SC_DIS_BIT];
                vis_nxt = sfr_i.wdata[`XDMD_SC_VIS_BIT];
                gen_nxt = sfr_i.wdata[`XDMD_SC_GEN_HI:`XDMD_SC_GEN_LO];
            end else if (sfr_i.addr == `XDMD_SFR_P2) begin
                p2_nxt = sfr_i.wdata;
                page_nxt = sfr_i.wdata;
            end else if (sfr_i.addr == `XDMD_SFR_PAGE) begin
                page_nxt = sfr_i.wdata;
            end
        end
        if (sfr_i.rd) begin
            if (sfr_i.addr == `XDMD_SFR_SYSCTL) begin
                // reserved bits are undefined; zero is given
                sfr_rd_nxt = 8'h00;
                sfr_rd_nxt[`XDMD_SC_DIS_BIT] = dis_r;
                sfr_rd_nxt[`XDMD_SC_VIS_BIT] = vis_r;
                sfr_rd_nxt[`XDMD_SC_GEN_HI:`XDMD_SC_GEN_LO] = gen_r;
            end else if (sfr_i.addr == `XDMD_SFR_P2) begin
                sfr_rd_nxt = p2_r;
            end else if (sfr_i.addr == `XDMD_SFR_PAGE) begin
                sfr_rd_nxt = page_r;
            end else begin
                sfr_rd_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            dis_r <= `XDMD_SC_DIS_RST;
            vis_r <= `XDMD_SC_VIS_RST;
            gen_r <= `XDMD_SC_GEN_RST;
            page_r <= `XDMD_PAGE_RST;
            p2_r <= `XDMD_P2_RST;
            sfr_rd_r <= 8'h00;
        end else begin
            dis_r <= dis_nxt;
            vis_r <= vis_nxt;
            gen_r <= gen_nxt;
            page_r <= page_nxt;
            p2_r <= p2_nxt;
            sfr_rd_r <= sfr_rd_nxt;
        end
    end

    // ****************************************************************
    // address decode
    // ****************************************************************
    function automatic xdmd_target_t decode(input logic [15:0] a, input logic dis);
        xdmd_target_t t;
        t = XDMD_TGT_EXT;
        if (dis) begin
            t = XDMD_TGT_EXT;
        end else if (a >= `XDMD_LCD_LO && a <= `XDMD_LCD_HI) begin
            t = XDMD_TGT_LCD;
        end else if (a >= `XDMD_RTC_LO && a <= `XDMD_RTC_HI) begin
            t = XDMD_TGT_RTC;
        end else if (a >= `XDMD_GAP_LO && a <= `XDMD_GAP_HI) begin
            t = XDMD_TGT_GAP;
        end else if (a >= `XDMD_ON_CHIP_XDATA_RAM_LO) begin
            t = XDMD_TGT_ON_CHIP_XDATA_RAM;
        end
        return t;
    endfunction

    logic [15:0] req_addr;
    xdmd_target_t req_tgt;

    always_comb begin
        // indexed moves take their high byte from the page register
        req_addr = mv_i.ptr16 ? mv_i.pointer : {page_r, mv_i.index};
        // outside every window the indexed move falls to the bus
        req_tgt = decode(req_addr, dis_r);
    end

    // ****************************************************************
    // move sequencer: two machine cycles per move
    // ****************************************************************
    xdmd_state_t st_r;
    xdmd_state_t st_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    xdmd_target_t tgt_r;
    xdmd_target_t tgt_nxt;
    logic wr_r;
    logic wr_nxt;
    logic p16_r;
    logic p16_nxt;
    logic [15:0] addr_r;
    logic [15:0] addr_nxt;
    logic [7:0] wd_r;
    logic [7:0] wd_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic done_r;
    logic done_nxt;
    logic ram_we;
    logic [7:0] ram_rdata;
    logic last;

    assign last = (cnt_r == CNT_LAST);
    // the write lands at the close of the first cycle unless reset is seen
    assign ram_we = (st_r == XDMD_ST_CYC1) && last && wr_r
                    && (tgt_r == XDMD_TGT_ON_CHIP_XDATA_RAM) && !srst_i;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        tgt_nxt = tgt_r;
        wr_nxt = wr_r;
        p16_nxt = p16_r;
        addr_nxt = addr_r;
        wd_nxt = wd_r;
        rdata_nxt = rdata_r;
        done_nxt = 1'b0;
        case (st_r)
            XDMD_ST_IDLE: begin
                if (mv_req_i) begin
                    st_nxt = XDMD_ST_CYC1;
                    cnt_nxt = '0;
                    tgt_nxt = req_tgt;
                    wr_nxt = mv_i.wr;
                    p16_nxt = mv_i.ptr16;
                    addr_nxt = req_addr;
                    wd_nxt = mv_i.wdata;
                end
            end
            XDMD_ST_CYC1: begin
                cnt_nxt = cnt_r + CW'(1);
                if (last) begin
                    st_nxt = XDMD_ST_CYC2;
                    cnt_nxt = '0;
                    if (!wr_r && tgt_r != XDMD_TGT_EXT) begin
                        wd_nxt = (tgt_r == XDMD_TGT_LCD) ? lcd_rdata_i
                                 : (tgt_r == XDMD_TGT_RTC) ? rtc_rdata_i : ram_rdata;
                    end
                end
            end
            XDMD_ST_CYC2: begin
                cnt_nxt = cnt_r + CW'(1);
                if (last) begin
                    st_nxt = XDMD_ST_IDLE;
                    cnt_nxt = '0;
                    done_nxt = 1'b1;
                    if (!wr_r) begin
                        case (tgt_r)
                            XDMD_TGT_EXT: rdata_nxt = pin_sync_r;
                            XDMD_TGT_LCD: rdata_nxt = lcd_rdata_i;
                            XDMD_TGT_RTC: rdata_nxt = rtc_rdata_i;
                            XDMD_TGT_ON_CHIP_XDATA_RAM: rdata_nxt = ram_rdata;
                            default: rdata_nxt = `XDMD_GAP_DATA;
                        endcase
                    end
                end
            end
            default: begin
                st_nxt = XDMD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st_r <= XDMD_ST_IDLE;
            cnt_r <= '0;
            tgt_r <= XDMD_TGT_EXT;
            wr_r <= 1'b0;
            p16_r <= 1'b0;
            addr_r <= 16'h0000;
            wd_r <= 8'h00;
            rdata_r <= 8'h00;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            tgt_r <= tgt_nxt;
            wr_r <= wr_nxt;
            p16_r <= p16_nxt;
            addr_r <= addr_nxt;
            wd_r <= wd_nxt;
            rdata_r <= rdata_nxt;
            done_r <= done_nxt;
        end
    end

    // ****************************************************************
    // on-chip ram
    // ****************************************************************
    // contents have no reset path at all
    xdmd_on_chip_xdata_ram #(
        .AW(8),
        .DW(8)
    ) u_on_chip_xdata_ram (
        .clk_sys_i(clk_sys_i),
        .we_i(ram_we),
        .addr_i(addr_r[7:0]),
        .wdata_i(wd_r),
        .rdata_o(ram_rdata)
    );

    // ****************************************************************
    // pin and peripheral outputs, registered from the next state
    // ****************************************************************
    logic rd_n_r;
    logic rd_n_nxt;
    logic wr_n_r;
    logic wr_n_nxt;
    logic hi_bus_r;
    logic hi_bus_nxt;
    logic lo_bus_r;
    logic lo_bus_nxt;
    logic oe_r;
    logic oe_nxt;
    logic lcd_r;
    logic lcd_nxt;
    logic rtc_r;
    logic rtc_nxt;
    logic mirror;
    logic active;

    always_comb begin
        active = (st_nxt != XDMD_ST_IDLE);
        // the disable bit already forced targets external; visibility acts in every window but the gap
        mirror = (tgt_nxt == XDMD_TGT_EXT)
                 || (vis_r && tgt_nxt != XDMD_TGT_GAP);
        lo_bus_nxt = active && mirror;
        hi_bus_nxt = active && mirror && p16_nxt;
        // strobes only in the second machine cycle, none when hidden
        rd_n_nxt = !(st_nxt == XDMD_ST_CYC2 && mirror && !wr_nxt);
        wr_n_nxt = !(st_nxt == XDMD_ST_CYC2 && mirror && wr_nxt);
        oe_nxt = (st_nxt == XDMD_ST_CYC2) && mirror && (wr_nxt || tgt_nxt != XDMD_TGT_EXT);
        lcd_nxt = (st_r == XDMD_ST_IDLE) && mv_req_i && (req_tgt == XDMD_TGT_LCD);
        rtc_nxt = (st_r == XDMD_ST_IDLE) && mv_req_i && (req_tgt == XDMD_TGT_RTC);
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            hi_bus_r <= 1'b0;
            lo_bus_r <= 1'b0;
            oe_r <= 1'b0;
            lcd_r <= 1'b0;
            rtc_r <= 1'b0;
        end else begin
            rd_n_r <= rd_n_nxt;
            wr_n_r <= wr_n_nxt;
            hi_bus_r <= hi_bus_nxt;
            lo_bus_r <= lo_bus_nxt;
            oe_r <= oe_nxt;
            lcd_r <= lcd_nxt;
            rtc_r <= rtc_nxt;
        end
    end

    // ****************************************************************
    // output wiring
    // ****************************************************************
    // port 2 keeps its latch value when it is not carrying the address
    assign ext_addr_o = hi_bus_r ? addr_r : {p2_r, addr_r[7:0]};
    assign ext_hi_bus_o = hi_bus_r;
    assign ext_lo_bus_o = lo_bus_r;
    assign ext_data_o = wd_r;
    assign ext_data_oe_o = oe_r;
    assign ext_rd_n_o = rd_n_r;
    assign ext_wr_n_o = wr_n_r;
    assign lcd_sel_o = lcd_r;
    assign rtc_sel_o = rtc_r;
    assign per_wr_o = wr_r;
    assign per_addr_o = addr_r[7:0];
    assign per_wdata_o = wd_r;
    assign mv_busy_o = (st_r != XDMD_ST_IDLE);
    assign mv_done_o = done_r;
    assign mv_rdata_o = rdata_r;
    assign sfr_rdata_o = sfr_rd_r;
    assign p2_latch_o = p2_r;

endmodule

// ==== dv/xdmd_decoder_chk.sv ====
// assertion checker for the external-data map decoder
`include "xdmd_regs.svh"

module xdmd_decoder_chk
    import xdmd_pkg::*;
#(
    parameter int MC_CLKS = 6 // clocks per machine cycle
) (
    input wire logic clk_sys_i, // system clock
    input wire logic srst_i, // synchronous reset
    input wire logic mv_req_i, // move request
    input wire xdmd_move_t mv_i, // move descriptor
    input wire logic mv_busy_o, // move in progress
    input wire logic mv_done_o, // move finished
    input wire logic [7:0] mv_rdata_o, // read result
    input wire xdmd_sfr_t sfr_i, // register access
    input wire logic [7:0] sfr_rdata_o, // register read data
    input wire logic [7:0] p2_latch_o, // port 2 latch
    input wire logic [15:0] ext_addr_o, // bus address
    input wire logic ext_hi_bus_o, // port 2 carries address
    input wire logic ext_lo_bus_o, // port 0 carries address
    input wire logic [7:0] ext_data_o, // bus write data
    input wire logic ext_data_oe_o, // bus drive enable
    input wire logic ext_rd_n_o, // read strobe
    input wire logic ext_wr_n_o, // write strobe
    input wire logic lcd_sel_o, // lcd pulse
    input wire logic rtc_sel_o, // rtc pulse
    input wire logic per_wr_o, // peripheral write flag
    input wire logic [7:0] per_addr_o, // peripheral offset
    input wire logic [7:0] per_wdata_o // peripheral write data
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MC_HI = MC_CLKS + 2;
    localparam int TWO_LO = 2 * MC_CLKS;
    localparam int TWO_HI = 2 * MC_CLKS + 1;
    logic dis_r, dis_nxt, vis_r, vis_nxt, take, is_lcd, is_rtc, is_win, show;
    logic [7:0] page_r, page_nxt, wdat_r, wdat_nxt;
    logic [15:0] addr, cap_r, cap_nxt;
    logic wr_r, wr_nxt, show_r, show_nxt, lcd_r, lcd_nxt, rtc_r, rtc_nxt, win_r, win_nxt;

    // ****************************************************************
    // shadow of control state, move captured when taken
    // ****************************************************************
    always_comb begin
        take = mv_req_i && !mv_busy_o;
        addr = mv_i.ptr16 ? mv_i.pointer : {page_r, mv_i.index};
        is_lcd = !dis_r && addr >= `XDMD_LCD_LO && addr <= `XDMD_LCD_HI;
        is_rtc = !dis_r && addr >= `XDMD_RTC_LO && addr <= `XDMD_RTC_HI;
        is_win = is_lcd || is_rtc || (!dis_r && addr >= `XDMD_ON_CHIP_XDATA_RAM_LO);
        // gap moves never reach the bus, whatever the visibility
        show = dis_r || addr < `XDMD_LCD_LO || (vis_r && is_win);
        {dis_nxt, vis_nxt, page_nxt} = {dis_r, vis_r, page_r};
        {cap_nxt, wdat_nxt, wr_nxt, show_nxt, lcd_nxt, rtc_nxt, win_nxt} =
            {cap_r, wdat_r, wr_r, show_r, lcd_r, rtc_r, win_r};
        if (sfr_i.wr && sfr_i.addr == `XDMD_SFR_SYSCTL) begin
            dis_nxt = dis_r && sfr_i.wdata[`XDMD_SC_DIS_BIT];
            vis_nxt = sfr_i.wdata[`XDMD_SC_VIS_BIT];
        end
        if (sfr_i.wr && (sfr_i.addr == `XDMD_SFR_PAGE || sfr_i.addr == `XDMD_SFR_P2)) begin
            page_nxt = sfr_i.wdata;
        end
        if (take && !srst_i) begin
            {cap_nxt, wdat_nxt, wr_nxt, show_nxt, lcd_nxt, rtc_nxt, win_nxt} =
                {addr, mv_i.wdata, mv_i.wr, show, is_lcd, is_rtc, is_win};
        end
        if (srst_i) begin
            {dis_nxt, vis_nxt, page_nxt} = {1'b1, 1'b0, `XDMD_PAGE_RST};
        end
    end
    always_ff @(posedge clk_sys_i) begin
        {dis_r, vis_r, page_r} <= {dis_nxt, vis_nxt, page_nxt};
        {cap_r, wdat_r, wr_r, show_r, lcd_r, rtc_r, win_r} <=
            {cap_nxt, wdat_nxt, wr_nxt, show_nxt, lcd_nxt, rtc_nxt, win_nxt};
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    AST_HIDDEN: assert property (mv_busy_o && !show_r |->
        ext_rd_n_o && ext_wr_n_o && !ext_lo_bus_o)
        else $error("bus activity on a hidden move");
    AST_STROBE: assert property (take && show |->
        ##[MC_CLKS:MC_HI] (wr_r ? !ext_wr_n_o : !ext_rd_n_o))
        else $error("missing strobe on a bus move");
    AST_ADDR: assert property (!ext_rd_n_o || !ext_wr_n_o |->
        ext_addr_o[7:0] == cap_r[7:0] && (!ext_hi_bus_o || ext_addr_o == cap_r))
        else $error("wrong bus address");
    AST_WDATA: assert property (!ext_wr_n_o |->
        ext_data_oe_o && ext_data_o == wdat_r)
        else $error("write data not driven");
    AST_DONE: assert property (take |-> ##[TWO_LO:TWO_HI] mv_done_o)
        else $error("move done late");
    AST_SEL: assert property (take |=> lcd_sel_o == lcd_r && rtc_sel_o == rtc_r)
        else $error("wrong window select");
    AST_RESET: assert property ($fell(srst_i) |->
        ext_rd_n_o && ext_wr_n_o && !mv_busy_o && p2_latch_o == `XDMD_P2_RST)
        else $error("bad state after reset");
    AST_CTRL: assert property (sfr_i.rd && sfr_i.addr == `XDMD_SFR_SYSCTL |=>
        sfr_rdata_o[1:0] == $past({vis_r, dis_r}))
        else $error("control bits read wrong");
    AST_P2: assert property (sfr_i.wr && sfr_i.addr == `XDMD_SFR_P2 |=>
        p2_latch_o == $past(sfr_i.wdata))
        else $error("port 2 latch not loaded");
    AST_PER: assert property (mv_busy_o |->
        per_wr_o == wr_r && per_addr_o == cap_r[7:0] && (!wr_r || per_wdata_o == wdat_r))
        else $error("wrong peripheral request");
    AST_RDVIS: assert property (mv_done_o && !wr_r && show_r && win_r |->
        $past(ext_data_oe_o) && $past(ext_data_o) == mv_rdata_o)
        else $error("visible read data not shown");
endmodule

bind xdmd_decoder xdmd_decoder_chk #(.MC_CLKS(MC_CLKS)) xdmd_decoder_chk_i (.clk_sys_i, .srst_i,
    .mv_req_i, .mv_i, .mv_busy_o, .mv_done_o, .sfr_i, .sfr_rdata_o, .p2_latch_o, .ext_addr_o,
    .ext_hi_bus_o, .ext_lo_bus_o, .ext_data_o, .ext_data_oe_o, .ext_rd_n_o, .ext_wr_n_o,
    .lcd_sel_o, .rtc_sel_o, .mv_rdata_o, .per_wr_o, .per_addr_o, .per_wdata_o);

// ==== dv/xdmd_ext_mem.sv ====
// external data memory and peripheral read model beside the decoder
module xdmd_ext_mem (
    input wire logic clk_sys_i, // system clock
    input wire logic [15:0] addr_i, // bus address
    input wire logic rd_n_i, // read strobe, active low
    input wire logic wr_n_i, // write strobe, active low
    input wire logic [7:0] wdata_i, // write data
    input wire logic oe_i, // write data drive enable
    input wire logic [7:0] per_addr_i, // peripheral register offset
    output logic [7:0] rdata_o, // port 0 level
    output logic [7:0] lcd_rdata_o, // lcd read data
    output logic [7:0] rtc_rdata_o, // rtc read data
    output logic [7:0] strb_cnt_o // strobe falls seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] rdq, last_r;
    logic rd_n_q, wr_n_q;

    // ****************************************************************
    // memory keyed on low byte, high byte folded into the data
    // ****************************************************************
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i);
        {last_r, strb_cnt_o, rd_n_q, wr_n_q} = {8'h00, 8'h00, 1'b1, 1'b1};
    end
    assign rdq = mem[addr_i[7:0]] ^ addr_i[15:8];
    // a released bus shows the inverse of the last value, never a stale copy
    assign rdata_o = !rd_n_i ? rdq : ~last_r;
    assign lcd_rdata_o = per_addr_i ^ 8'h5a;
    assign rtc_rdata_o = per_addr_i ^ 8'hc3;
    always @(posedge clk_sys_i) begin
        {rd_n_q, wr_n_q} <= {rd_n_i, wr_n_i};
        if (!rd_n_i) last_r <= rdq;
        if (!wr_n_i && oe_i) mem[addr_i[7:0]] <= wdata_i ^ addr_i[15:8];
        if ((rd_n_q && !rd_n_i) || (wr_n_q && !wr_n_i)) strb_cnt_o <= strb_cnt_o + 8'h01;
    end
endmodule

// ==== dv/testbench.sv ====
// self-checking bench for the external-data map decoder
`include "xdmd_regs.svh"
`define CHK(nm, ex, sn) begin \
    comparisons++; \
    if ((sn) !== (ex)) begin \
        mismatches++; \
        $display("Error %s expected %h seen %h", nm, ex, sn); \
    end \
end

module testbench
    import xdmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MC = 4;
    logic clk_sys_i, srst_i, mv_req, mv_busy, mv_done, ext_oe, ext_rd_n, ext_wr_n;
    logic [7:0] mv_rdata, sfr_rdata, p2_latch, ext_do, ext_di, per_addr, lcd_rd, rtc_rd, strb_cnt;
    logic [15:0] ext_addr;
    xdmd_move_t mv;
    xdmd_sfr_t sfr;
    int mismatches, comparisons;

    xdmd_decoder #(.MC_CLKS(MC)) xdmd_decoder_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .mv_req_i(mv_req), .mv_i(mv), .mv_busy_o(mv_busy), .mv_done_o(mv_done),
        .mv_rdata_o(mv_rdata), .sfr_i(sfr), .sfr_rdata_o(sfr_rdata), .p2_latch_o(p2_latch),
        .ext_addr_o(ext_addr), .ext_hi_bus_o(), .ext_lo_bus_o(), .ext_data_o(ext_do),
        .ext_data_oe_o(ext_oe), .ext_data_i(ext_di), .ext_rd_n_o(ext_rd_n), .ext_wr_n_o(ext_wr_n),
        .lcd_sel_o(), .rtc_sel_o(), .per_wr_o(), .per_addr_o(per_addr), .per_wdata_o(),
        .lcd_rdata_i(lcd_rd), .rtc_rdata_i(rtc_rd));
    xdmd_ext_mem xdmd_ext_mem_i (.clk_sys_i(clk_sys_i), .addr_i(ext_addr), .rd_n_i(ext_rd_n),
        .wr_n_i(ext_wr_n), .wdata_i(ext_do), .oe_i(ext_oe), .per_addr_i(per_addr),
        .rdata_o(ext_di), .lcd_rdata_o(lcd_rd), .rtc_rdata_o(rtc_rd), .strb_cnt_o(strb_cnt));

    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic close_out();
        if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_i);
        sfr <= '0;
        #1;
    endtask
    task automatic chk_sfr(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys_i);
        sfr <= '0;
        #1;
        `CHK("sfr_rdata_o", e, sfr_rdata)
    endtask
    // reset lands n edges after the move is taken
    task automatic start(input logic wr, input logic p16, input logic [15:0] a,
            input logic [7:0] d, input int n);
        @(posedge clk_sys_i);
        mv_req <= 1'b1;
        mv <= '{wr: wr, ptr16: p16, pointer: a, index: a[7:0], wdata: d};
        @(posedge clk_sys_i);
        mv_req <= 1'b0;
        if (n > 0) begin
            repeat (n) @(posedge clk_sys_i);
            srst_i <= 1'b1;
            repeat (20) @(posedge clk_sys_i);
            srst_i <= 1'b0;
        end
    endtask
    task automatic move(input logic wr, input logic p16, input logic [15:0] a,
            input logic [7:0] d, input logic [7:0] eq, input logic [7:0] ens);
        logic [7:0] c0;
        int n;
        c0 = strb_cnt;
        start(wr, p16, a, d, 0);
        n = 0;
        while (mv_done !== 1'b1 && n < 60) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        if (n >= 60) begin
            mismatches++;
            close_out();
        end
        if (!wr) `CHK("mv_rdata_o", eq, mv_rdata)
        `CHK("strobe count", ens, 8'(strb_cnt - c0))
    endtask

    initial begin
        {srst_i, mv_req, mv, sfr, mismatches, comparisons} = '0;
        srst_i = 1'b1;
        repeat (20) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        chk_sfr(`XDMD_SFR_SYSCTL, 8'h21);
        chk_sfr(`XDMD_SFR_PAGE, 8'h00);
        move(1'b1, 1'b1, 16'hff10, 8'h5c, 8'h00, 8'h01);
        move(1'b0, 1'b1, 16'hff10, 8'h00, 8'h5c, 8'h01);
        move(1'b0, 1'b1, 16'hf3e4, 8'h00, 8'h17, 8'h01);
        move(1'b0, 1'b1, 16'hf3f5, 8'h00, 8'h06, 8'h01);
        sfr_wr(`XDMD_SFR_SYSCTL, 8'h20);
        sfr_wr(`XDMD_SFR_SYSCTL, 8'h21);
        chk_sfr(`XDMD_SFR_SYSCTL, 8'h20);
        move(1'b1, 1'b1, 16'hff10, 8'ha7, 8'h00, 8'h00);
        move(1'b0, 1'b1, 16'hff10, 8'h00, 8'ha7, 8'h00);
        move(1'b0, 1'b1, 16'hf3e4, 8'h00, 8'hbe, 8'h00);
        move(1'b0, 1'b1, 16'hf3f5, 8'h00, 8'h36, 8'h00);
        move(1'b0, 1'b1, 16'hf500, 8'h00, `XDMD_GAP_DATA, 8'h00);
        move(1'b0, 1'b1, 16'hf3db, 8'h00, 8'h28, 8'h01);
        sfr_wr(`XDMD_SFR_SYSCTL, 8'h22);
        move(1'b1, 1'b1, 16'hff11, 8'h3e, 8'h00, 8'h01);
        move(1'b0, 1'b1, 16'hff11, 8'h00, 8'h3e, 8'h01);
        move(1'b0, 1'b1, 16'hf3dc, 8'h00, 8'h86, 8'h01);
        move(1'b0, 1'b1, 16'hf500, 8'h00, `XDMD_GAP_DATA, 8'h00);
        sfr_wr(`XDMD_SFR_SYSCTL, 8'h20);
        sfr_wr(`XDMD_SFR_P2, 8'haa);
        `CHK("p2_latch_o", 8'haa, p2_latch)
        chk_sfr(`XDMD_SFR_PAGE, 8'haa);
        sfr_wr(`XDMD_SFR_PAGE, 8'hff);
        `CHK("p2_latch_o", 8'haa, p2_latch)
        move(1'b0, 1'b0, 16'h0010, 8'h00, 8'ha7, 8'h00);
        sfr_wr(`XDMD_SFR_P2, 8'h12);
        move(1'b0, 1'b0, 16'h0034, 8'h00, 8'h26, 8'h01);
        move(1'b1, 1'b1, 16'hff20, 8'h11, 8'h00, 8'h00);
        start(1'b1, 1'b1, 16'hff20, 8'h99, MC - 1);
        chk_sfr(`XDMD_SFR_SYSCTL, 8'h21);
        `CHK("p2_latch_o", `XDMD_P2_RST, p2_latch)
        sfr_wr(`XDMD_SFR_SYSCTL, 8'h20);
        move(1'b0, 1'b1, 16'hff20, 8'h00, 8'h11, 8'h00);
        move(1'b0, 1'b1, 16'hff10, 8'h00, 8'ha7, 8'h00);
        move(1'b1, 1'b1, 16'hff21, 8'h11, 8'h00, 8'h00);
        start(1'b1, 1'b1, 16'hff21, 8'h77, MC + 1);
        sfr_wr(`XDMD_SFR_SYSCTL, 8'h20);
        move(1'b0, 1'b1, 16'hff21, 8'h00, 8'h77, 8'h00);
        close_out();
    end
endmodule
